// [design/gcfs_map.svh]
// Register indices, field positions, reset values and timing counts
// for the gyroscope configuration and queue-select register bank.
// Assumes a 100 MHz register clock; byte address is four times index.
`ifndef GCFS_MAP_SVH
`define GCFS_MAP_SVH

// Register indices.
`define GCFS_IDX_SAMPLE_DIV 10'h019
`define GCFS_IDX_CONFIG 10'h01A
`define GCFS_IDX_GYRO_CFG 10'h01B
`define GCFS_IDX_LP_CFG 10'h01E
`define GCFS_IDX_FIFO_SEL 10'h023
`define GCFS_IDX_FRAME_SYNC_PIN_STAT 10'h036
`define GCFS_IDX_PIN_CFG 10'h037
`define GCFS_IDX_IRQ_STAT 10'h03C
`define GCFS_IDX_IRQ_MASK 10'h03D

// Writable-bit masks; reserved bits are held at zero.
`define GCFS_MASK_GYRO_CFG 8'hFB
`define GCFS_MASK_LP_CFG 8'hF0
`define GCFS_MASK_FIFO_SEL 8'hF0
`define GCFS_MASK_CONFIG 8'h7F
`define GCFS_MASK_PIN_CFG 8'h0C
`define GCFS_MASK_IRQ 8'h07

// Reset values.
`define GCFS_RST_REG 8'h00

// Field positions.
`define GCFS_BIT_XST 7
`define GCFS_BIT_YST 6
`define GCFS_BIT_ZST 5
`define GCFS_RANGE_HI 4
`define GCFS_RANGE_LO 3
`define GCFS_BYP_HI 1
`define GCFS_BYP_LO 0
`define GCFS_BIT_CYCLE 7
`define GCFS_AVG_HI 6
`define GCFS_AVG_LO 4
`define GCFS_SEL_HI 7
`define GCFS_SEL_LO 4
`define GCFS_BIT_FIFO_MODE 6
`define GCFS_LPF_HI 2
`define GCFS_LPF_LO 0
`define GCFS_BIT_FS_LEVEL 3
`define GCFS_BIT_FS_IRQ_EN 2
`define GCFS_BIT_FS_FLAG 7
`define GCFS_IRQ_FRAME_SYNC_PIN 0
`define GCFS_IRQ_SAMPLE 1
`define GCFS_IRQ_DROP 2

// Timing: internal rate period and clock period, both in ns.
`define GCFS_INT_PERIOD_NS 1000000
`define GCFS_CLK_PERIOD_NS 10
`define GCFS_TICK_CYCLES (`GCFS_INT_PERIOD_NS / `GCFS_CLK_PERIOD_NS)

`endif

// [design/gcfs_pkg.sv]
// Types shared by the gyroscope configuration register bank.
// Assumes the constants of gcfs_map.svh for all numeric values.
package gcfs_pkg;

  // One-hot states of the queue push sequencer.
  typedef enum logic [1:0] {
    GCFS_IDLE = 2'b01,
    GCFS_PUSH = 2'b10
  } gcfs_state_t;

  // Angular range codes: 250, 500, 1000 and 2000 dps.
  typedef enum logic [1:0] {
    GCFS_R250 = 2'h0,
    GCFS_R500 = 2'h1,
    GCFS_R1000 = 2'h2,
    GCFS_R2000 = 2'h3
  } gcfs_range_t;

endpackage

// [design/gcfs_rate_gen.sv]
// Sample-rate strobe generator: internal rate divided by divider + 1.
// Assumes a synchronous divider value from the register bank.
`timescale 1ns/1ps
`include "gcfs_map.svh"
module gcfs_rate_gen
  import gcfs_pkg::*;
#(
  parameter int TICK_CYCLES = `GCFS_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control and strobe.
  input wire logic [7:0] sample_divider,
  output logic sample_tick
);

  logic [19:0] ms_cnt;
  logic [7:0] div_cnt;
  logic ms_tick;

  // Internal-rate period counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt <= 20'h00000;
    end else if (ms_tick) begin
      ms_cnt <= 20'h00000;
    end else begin
      ms_cnt <= ms_cnt + 20'h00001;
    end
  end

  assign ms_tick = (ms_cnt == 20'(TICK_CYCLES - 1));

  // Divider; a smaller new divider takes effect at the next tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 8'h00;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= 1'b0;
      if (ms_tick) begin
        if (div_cnt >= sample_divider) begin
          div_cnt <= 8'h00;
          sample_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end
    end
  end

endmodule

// [design/gcfs_regs.sv]
// Gyroscope configuration, low-power, queue-select and frame-sync
// register bank with an APB slave and a sticky interrupt block.
// Assumes synchronous inputs on pclk and an external byte queue.
// Functional notes
// - Range field bits 4:3 select 250, 500, 1000 or 2000 dps.
// - Bits 1:0 select main low-pass use or bypass.
// - Low-power bit 7 enables cycling mode; resets to zero.
// - Averaging selector bits 6:4 set low-power averaging; reset 000.
// - In low-power mode only the averaging selector sets filtering.
// - Selector n averages two to the power n samples.
// - Temperature bit pushes its high and low bytes each strobe.
// - Bits 6, 5, 4 push X, Y, Z high and low bytes.
// - Enabled paths are queued even when in standby.
// - Hardware sets the frame-sync flag on each frame-sync event.
// - Reading the frame-sync status returns the flag then clears it.
// - Sample rate is 1 kHz divided by divider plus one.
// - Main low-pass filter used only when bypass selector is 00.
// - Queue full: mode set drops samples, clear overwrites oldest.
// - Frame-sync pin raises the flag only when its enable is set.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "gcfs_map.svh"
module gcfs_regs
  import gcfs_pkg::*;
#(
  parameter int TICK_CYCLES = `GCFS_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sensor data and standby-independent sources.
  input wire logic [15:0] temp_out,
  input wire logic [15:0] x_rate,
  input wire logic [15:0] y_rate,
  input wire logic [15:0] z_rate,
  input wire logic frame_sync_pin,
  // Byte queue write side.
  input wire logic fifo_full,
  output logic fifo_push,
  output logic [7:0] fifo_byte,
  output logic fifo_overwrite,
  // Filter and range controls.
  output logic x_axis_selftest,
  output logic y_axis_selftest,
  output logic z_axis_selftest,
  output gcfs_range_t range_select,
  output logic [1:0] filter_bypass_sel,
  output logic lowpass_en,
  output logic [2:0] lowpass_cfg_code,
  output logic lp_cycle_en,
  output logic [2:0] avg_filter_sel,
  output logic [7:0] avg_samples,
  output logic sample_tick,
  // Interrupt.
  output logic irq
);

  logic [7:0] gyro_range_config;
  logic [7:0] low_power_cycle_config;
  logic [7:0] fifo_source_select;
  logic [7:0] sample_divider;
  logic [7:0] config_reg;
  logic [7:0] pin_cfg;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic frame_sync_event_flag;
  logic [9:0] reg_idx;
  logic addr_ok;
  logic wr_acc;
  logic rd_acc;
  logic setup;
  logic [7:0] next_rdata;
  logic next_err;
  logic fs_prev;
  logic fs_active;
  logic fs_event;
  gcfs_state_t state;
  logic [2:0] byte_idx;
  logic [63:0] snap;
  logic [3:0] snap_sel;
  logic byte_want;
  logic drop_event;

  // Bus phases; data is latched in setup so the access needs no wait.
  assign reg_idx = paddr[11:2];
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = psel && penable;

  // Read mux and address decode.
  always_comb begin
    next_rdata = 8'h00;
    addr_ok = (paddr[1:0] == 2'h0);
    if (reg_idx == `GCFS_IDX_SAMPLE_DIV) begin
      next_rdata = sample_divider;
    end else if (reg_idx == `GCFS_IDX_CONFIG) begin
      next_rdata = config_reg;
    end else if (reg_idx == `GCFS_IDX_GYRO_CFG) begin
      next_rdata = gyro_range_config;
    end else if (reg_idx == `GCFS_IDX_LP_CFG) begin
      next_rdata = low_power_cycle_config;
    end else if (reg_idx == `GCFS_IDX_FIFO_SEL) begin
      next_rdata = fifo_source_select;
    end else if (reg_idx == `GCFS_IDX_FRAME_SYNC_PIN_STAT) begin
      next_rdata[`GCFS_BIT_FS_FLAG] = frame_sync_event_flag;
    end else if (reg_idx == `GCFS_IDX_PIN_CFG) begin
      next_rdata = pin_cfg;
    end else if (reg_idx == `GCFS_IDX_IRQ_STAT) begin
      next_rdata = irq_status;
    end else if (reg_idx == `GCFS_IDX_IRQ_MASK) begin
      next_rdata = irq_mask;
    end else begin
      addr_ok = 1'b0;
    end
    next_err = !addr_ok;
  end

  // Read data and error are captured in the setup phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= {24'h000000, (addr_ok ? next_rdata : 8'h00)};
      pslverr <= next_err;
    end
  end

  // Writable registers; masks keep reserved bits at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gyro_range_config <= `GCFS_RST_REG;
      low_power_cycle_config <= `GCFS_RST_REG;
      fifo_source_select <= `GCFS_RST_REG;
      sample_divider <= `GCFS_RST_REG;
      config_reg <= `GCFS_RST_REG;
      pin_cfg <= `GCFS_RST_REG;
      irq_mask <= `GCFS_RST_REG;
    end else if (wr_acc && addr_ok) begin
      if (reg_idx == `GCFS_IDX_GYRO_CFG) begin
        gyro_range_config <= pwdata[7:0] & `GCFS_MASK_GYRO_CFG;
      end else if (reg_idx == `GCFS_IDX_LP_CFG) begin
        low_power_cycle_config <= pwdata[7:0] & `GCFS_MASK_LP_CFG;
      end else if (reg_idx == `GCFS_IDX_FIFO_SEL) begin
        fifo_source_select <= pwdata[7:0] & `GCFS_MASK_FIFO_SEL;
      end else if (reg_idx == `GCFS_IDX_SAMPLE_DIV) begin
        sample_divider <= pwdata[7:0];
      end else if (reg_idx == `GCFS_IDX_CONFIG) begin
        config_reg <= pwdata[7:0] & `GCFS_MASK_CONFIG;
      end else if (reg_idx == `GCFS_IDX_PIN_CFG) begin
        pin_cfg <= pwdata[7:0] & `GCFS_MASK_PIN_CFG;
      end else if (reg_idx == `GCFS_IDX_IRQ_MASK) begin
        irq_mask <= pwdata[7:0] & `GCFS_MASK_IRQ;
      end
    end
  end

  // Decoded controls; low-power mode clears the low-pass enable, the code passes through.
  assign x_axis_selftest = gyro_range_config[`GCFS_BIT_XST];
  assign y_axis_selftest = gyro_range_config[`GCFS_BIT_YST];
  assign z_axis_selftest = gyro_range_config[`GCFS_BIT_ZST];
  assign range_select = gcfs_range_t'(
    gyro_range_config[`GCFS_RANGE_HI:`GCFS_RANGE_LO]);
  assign filter_bypass_sel =
    gyro_range_config[`GCFS_BYP_HI:`GCFS_BYP_LO];
  assign lp_cycle_en = low_power_cycle_config[`GCFS_BIT_CYCLE];
  assign avg_filter_sel =
    low_power_cycle_config[`GCFS_AVG_HI:`GCFS_AVG_LO];
  assign lowpass_en = (filter_bypass_sel == 2'h0) && !lp_cycle_en;
  assign lowpass_cfg_code = config_reg[`GCFS_LPF_HI:`GCFS_LPF_LO];
  // Without low-power mode the averager passes single samples.
  assign avg_samples = lp_cycle_en ? (8'h01 << avg_filter_sel)
                                   : 8'h01;

  // Sample-rate strobe paces every queue write.
  gcfs_rate_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .sample_divider(sample_divider),
    .sample_tick(sample_tick)
  );

  // Frame-sync edge toward the configured level.
  assign fs_active = frame_sync_pin ^ pin_cfg[`GCFS_BIT_FS_LEVEL];
  assign fs_event = pin_cfg[`GCFS_BIT_FS_IRQ_EN]
                    && fs_active && !fs_prev;

  // Previous active state of the pin; an edge needs a fresh transition.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_prev <= 1'b0;
    end else begin
      fs_prev <= fs_active;
    end
  end

  // Only the flag value actually returned is cleared, and a new event
  // wins, so an event during a read is never lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_sync_event_flag <= 1'b0;
    end else if (fs_event) begin
      frame_sync_event_flag <= 1'b1;
    end else if (rd_acc && reg_idx == `GCFS_IDX_FRAME_SYNC_PIN_STAT &&
                 prdata[`GCFS_BIT_FS_FLAG]) begin
      frame_sync_event_flag <= 1'b0;
    end
  end

  // Push sequencer: snapshot on the strobe, then walk eight byte slots
  // high byte first, temperature, X, Y, Z. Standby is not consulted.
  assign byte_want = (state == GCFS_PUSH) &&
                     snap_sel[3 - int'(byte_idx[2:1])];
  assign drop_event = byte_want && fifo_full &&
                      config_reg[`GCFS_BIT_FIFO_MODE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= GCFS_IDLE;
      byte_idx <= 3'h0;
      snap <= 64'h0000000000000000;
      snap_sel <= 4'h0;
    end else begin
      case (state)
        GCFS_IDLE: begin
          if (sample_tick) begin
            snap <= {temp_out, x_rate, y_rate, z_rate};
            snap_sel <= fifo_source_select[`GCFS_SEL_HI:`GCFS_SEL_LO];
            byte_idx <= 3'h0;
            state <= GCFS_PUSH;
          end
        end
        GCFS_PUSH: begin
          byte_idx <= byte_idx + 3'h1;
          if (byte_idx == 3'h7) begin
            state <= GCFS_IDLE;
          end
        end
        default: begin
          state <= GCFS_IDLE;
        end
      endcase
    end
  end

  // Queue write port; full with mode set drops, else overwrites.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_push <= 1'b0;
      fifo_byte <= 8'h00;
      fifo_overwrite <= 1'b0;
    end else begin
      fifo_push <= byte_want && !drop_event;
      fifo_byte <= snap[63 - 8 * int'(byte_idx) -: 8];
      fifo_overwrite <= byte_want && fifo_full && !drop_event;
    end
  end

  // Sticky interrupt status; read clears returned bits, set wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= `GCFS_RST_REG;
    end else begin
      irq_status <= (irq_status &
        ~((rd_acc && reg_idx == `GCFS_IDX_IRQ_STAT) ? prdata[7:0] : 8'h00))
        | {5'h00, drop_event, sample_tick, fs_event};
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Every check runs on the bus clock and rests while reset is low.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Frame-sync flag: set by a qualified edge, cleared only by its read.
  a_frame_sync_pin_flag_set: assert property (
    fs_event |=> frame_sync_event_flag)
    else $error("frame-sync flag not set");
  a_frame_sync_pin_read_clear: assert property (
    rd_acc && !fs_event && reg_idx == `GCFS_IDX_FRAME_SYNC_PIN_STAT &&
    prdata[7] |=> !frame_sync_event_flag)
    else $error("frame-sync flag not cleared by read");
  a_frame_sync_pin_gated: assert property (
    $rose(frame_sync_event_flag) |-> $past(pin_cfg[`GCFS_BIT_FS_IRQ_EN]))
    else $error("frame-sync flag set while disabled");

  // Queue slots land one per cycle from two cycles after the strobe, high byte first.
  a_temp_push_bytes: assert property (
    sample_tick && state == GCFS_IDLE && fifo_source_select[7] &&
    !config_reg[6] |=> ##1
    fifo_push && fifo_byte == $past(temp_out[15:8], 2) ##1
    fifo_push && fifo_byte == $past(temp_out[7:0], 3))
    else $error("temperature bytes not pushed");
  a_x_push_bytes: assert property (
    sample_tick && state == GCFS_IDLE &&
    fifo_source_select[7:4] == 4'h4 && !config_reg[6] |=>
    !fifo_push [*3] ##1 fifo_push && fifo_byte == $past(x_rate[15:8], 4))
    else $error("X rate bytes misplaced");
  a_none_pushed: assert property (
    sample_tick && state == GCFS_IDLE &&
    fifo_source_select[7:4] == 4'h0 |=> !fifo_push [*8])
    else $error("push without any source enabled");
  a_drop_when_full: assert property (
    drop_event |=> !fifo_push && !fifo_overwrite)
    else $error("full queue written in drop mode");
  a_overwrite_push: assert property (
    fifo_overwrite |-> fifo_push)
    else $error("overwrite mark without a push");
  a_tick_single: assert property (
    sample_tick |=> !sample_tick)
    else $error("sample strobe longer than one cycle");

  // Filter controls: low-power mode hands filtering to the averager.
  a_lp_overrides: assert property (
    lp_cycle_en |->
    !lowpass_en && avg_samples == (8'h01 << avg_filter_sel))
    else $error("low-power filtering wrong");
  a_lpf_bypass: assert property (
    lowpass_en |-> filter_bypass_sel == 2'h0 && !lp_cycle_en)
    else $error("low-pass used while bypassed");

  // Reserved bits are never stored and never read back as ones.
  a_reserved_held: assert property (
    gyro_range_config[2] == 1'b0 && low_power_cycle_config[3:0] == 4'h0 &&
    fifo_source_select[3:0] == 4'h0)
    else $error("reserved register bit set");
  a_reserved_zero: assert property (
    rd_acc && reg_idx == `GCFS_IDX_GYRO_CFG |->
    prdata[2] == 1'b0 && prdata[31:8] == 24'h000000)
    else $error("reserved bit read nonzero");

  // Main scenarios that every regression should reach.
  c_frame_sync_pin_read: cover property (rd_acc && prdata[7] &&
    reg_idx == `GCFS_IDX_FRAME_SYNC_PIN_STAT);
  c_full_sample: cover property (sample_tick &&
    fifo_source_select[7:4] == 4'hF);
  c_drop: cover property (drop_event);
  c_irq: cover property ($rose(irq));

endmodule

// [tb/gcfs_tb.sv]
// Self-checking bench for the gyroscope configuration register bank.
// Assumes the design files and gcfs_map.svh are compiled before it.
`timescale 1ns/1ps
`include "gcfs_map.svh"
module testbench;
  import gcfs_pkg::*;
  // A short tick keeps each internal-rate period at twenty clocks.
  localparam int TICKS = 20;
  localparam logic [11:0] A_DIV = {`GCFS_IDX_SAMPLE_DIV, 2'b00};
  localparam logic [11:0] A_CFG = {`GCFS_IDX_CONFIG, 2'b00};
  localparam logic [11:0] A_GYRO = {`GCFS_IDX_GYRO_CFG, 2'b00};
  localparam logic [11:0] A_LP = {`GCFS_IDX_LP_CFG, 2'b00};
  localparam logic [11:0] A_FSEL = {`GCFS_IDX_FIFO_SEL, 2'b00};
  localparam logic [11:0] A_FS = {`GCFS_IDX_FRAME_SYNC_PIN_STAT, 2'b00};
  localparam logic [11:0] A_PIN = {`GCFS_IDX_PIN_CFG, 2'b00};
  localparam logic [11:0] A_IST = {`GCFS_IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_MASK = {`GCFS_IDX_IRQ_MASK, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] temp_out, x_rate, y_rate, z_rate;
  logic frame_sync_pin, fifo_full, fifo_push, fifo_overwrite;
  logic [7:0] fifo_byte, avg_samples;
  logic x_axis_selftest, y_axis_selftest, z_axis_selftest;
  gcfs_range_t range_select;
  logic [1:0] filter_bypass_sel;
  logic [2:0] lowpass_cfg_code, avg_filter_sel;
  logic lowpass_en, lp_cycle_en, sample_tick, irq;
  int errors = 0;
  int checks_done = 0;

  gcfs_regs #(.TICK_CYCLES(TICKS)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .temp_out(temp_out),
    .x_rate(x_rate), .y_rate(y_rate), .z_rate(z_rate),
    .frame_sync_pin(frame_sync_pin), .fifo_full(fifo_full),
    .fifo_push(fifo_push), .fifo_byte(fifo_byte),
    .fifo_overwrite(fifo_overwrite), .x_axis_selftest(x_axis_selftest),
    .y_axis_selftest(y_axis_selftest), .z_axis_selftest(z_axis_selftest),
    .range_select(range_select), .filter_bypass_sel(filter_bypass_sel),
    .lowpass_en(lowpass_en), .lowpass_cfg_code(lowpass_cfg_code),
    .lp_cycle_en(lp_cycle_en), .avg_filter_sel(avg_filter_sel),
    .avg_samples(avg_samples), .sample_tick(sample_tick), .irq(irq)
  );

  // Free-running 100 MHz clock.
  always #5 pclk = ~pclk;

  // Prints the counts and the verdict, then ends the run.
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compares with case equality so an unknown never passes.
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the leading edge keeps psel from two drives at once.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      report_and_stop();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input string what, input logic [11:0] a,
                     input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    check(what, r, exp);
  endtask

  // Waits for the next strobe and returns the cycles it took.
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sample_tick !== 1'b1 && n < 400);
    if (sample_tick !== 1'b1) begin
      errors++;
      report_and_stop();
    end
  endtask

  // Collects every byte pushed in the 14 cycles after the next strobe.
  task automatic collect(output int ow, ref logic [7:0] got[$]);
    int n;
    ow = 0;
    wait_tick(n);
    repeat (14) begin
      @(posedge pclk);
      if (fifo_push === 1'b1) got.push_back(fifo_byte);
      if (fifo_push === 1'b1 && fifo_overwrite === 1'b1) ow++;
    end
  endtask

  task automatic t_reset;
    check("range", range_select, 0);
    check("cycle en", lp_cycle_en, 0);
    check("irq", irq, 0);
    rdc("gyro reset", A_GYRO, `GCFS_RST_REG);
    rdc("lp reset", A_LP, 32'h00);
    rdc("sel reset", A_FSEL, 32'h00);
    rdc("flag reset", A_FS, 32'h00);
    $display("test reset done");
  endtask

  task automatic t_gyro;
    wr(A_GYRO, 8'hFF);
    rdc("gyro rsvd", A_GYRO, 32'hFB);
    wr(A_GYRO, 8'hA0);
    check("selftest", {x_axis_selftest, y_axis_selftest,
          z_axis_selftest}, 3'b101);
    for (int i = 0; i < 4; i++) begin
      wr(A_GYRO, {3'b000, i[1:0], 1'b0, i[1:0]});
      check("range", range_select, i);
      check("bypass", filter_bypass_sel, i);
      check("lowpass en", lowpass_en, i == 0);
    end
    $display("test gyro done");
  endtask

  task automatic t_low_power;
    wr(A_LP, 8'hFF);
    rdc("lp rsvd", A_LP, 32'hF0);
    wr(A_FSEL, 8'hFF);
    rdc("sel rsvd", A_FSEL, 32'hF0);
    wr(A_GYRO, 8'h00);
    wr(A_CFG, 8'h05);
    check("lpf code", lowpass_cfg_code, 3'h5);
    // Every averaging code, with the main filter code still set.
    for (int n = 0; n < 8; n++) begin
      wr(A_LP, {1'b1, n[2:0], 4'h0});
      check("cycle en", lp_cycle_en, 1);
      check("avg sel", avg_filter_sel, n);
      check("avg count", avg_samples, 1 << n);
      check("lowpass off", lowpass_en, 0);
    end
    wr(A_LP, 8'h00);
    check("avg single", avg_samples, 1);
    check("lowpass back", lowpass_en, 1);
    wr(A_CFG, 8'h00);
    $display("test low power done");
  endtask

  task automatic t_queue;
    logic [7:0] sels[7] = '{8'hF0, 8'h80, 8'h40, 8'h20, 8'h10, 8'hA0, 8'h00};
    logic [7:0] got[$];
    logic [7:0] exp[$];
    int ow;
    foreach (sels[s]) begin
      got.delete();
      exp.delete();
      wr(A_FSEL, sels[s]);
      collect(ow, got);
      if (sels[s][7]) exp = {exp, temp_out[15:8], temp_out[7:0]};
      if (sels[s][6]) exp = {exp, x_rate[15:8], x_rate[7:0]};
      if (sels[s][5]) exp = {exp, y_rate[15:8], y_rate[7:0]};
      if (sels[s][4]) exp = {exp, z_rate[15:8], z_rate[7:0]};
      check("push count", got.size(), exp.size());
      for (int i = 0; i < exp.size() && i < got.size(); i++)
        check("queue byte", got[i], exp[i]);
    end
    $display("test queue done");
  endtask

  task automatic t_full;
    logic [7:0] got[$];
    logic [31:0] r;
    logic e;
    int ow;
    wr(A_CFG, 8'h40);
    wr(A_FSEL, 8'h80);
    @(posedge pclk);
    fifo_full <= 1'b1;
    collect(ow, got);
    check("drop pushes", got.size(), 0);
    apb(1'b0, A_IST, 8'h00, r, e);
    check("drop status", r & 32'h4, 32'h4);
    got.delete();
    wr(A_CFG, 8'h00);
    collect(ow, got);
    check("overwrite pushes", got.size(), 2);
    check("overwrite marks", ow, 2);
    @(posedge pclk);
    fifo_full <= 1'b0;
    wr(A_FSEL, 8'h00);
    $display("test full done");
  endtask

  // Pulses the pin away from its idle level for one cycle.
  task automatic pin_pulse(input logic idle);
    @(posedge pclk);
    frame_sync_pin <= ~idle;
    @(posedge pclk);
    frame_sync_pin <= idle;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task automatic t_frame_sync_pin;
    logic [31:0] r;
    logic e;
    wr(A_PIN, 8'h04);
    wr(A_MASK, 8'h01);
    apb(1'b0, A_IST, 8'h00, r, e);
    pin_pulse(1'b0);
    check("irq raised", irq, 1);
    rdc("flag set", A_FS, 32'h80);
    rdc("flag cleared", A_FS, 32'h00);
    apb(1'b0, A_IST, 8'h00, r, e);
    check("irq cleared", irq, 0);
    wr(A_MASK, 8'h00);
    pin_pulse(1'b0);
    check("irq masked", irq, 0);
    rdc("flag unmasked", A_FS, 32'h80);
    wr(A_PIN, 8'h00);
    pin_pulse(1'b0);
    rdc("flag disabled", A_FS, 32'h00);
    @(posedge pclk);
    frame_sync_pin <= 1'b1;
    wr(A_PIN, 8'h0C);
    pin_pulse(1'b1);
    rdc("flag low level", A_FS, 32'h80);
    $display("test frame sync done");
  endtask

  task automatic t_misc;
    logic [31:0] r;
    logic e;
    int n;
    apb(1'b0, 12'h0FC, 8'h00, r, e);
    check("unmapped err", e, 1);
    check("unmapped data", r, 0);
    wr(A_GYRO, 8'h08);
    apb(1'b1, A_GYRO | 12'h001, 8'hFF, r, e);
    check("misaligned err", e, 1);
    rdc("gyro kept", A_GYRO, 32'h08);
    // Averaging stays single-sample, the one pairing usable at any rate.
    wr(A_DIV, 8'h02);
    wait_tick(n);
    wait_tick(n);
    wait_tick(n);
    check("tick period", n, 3 * TICKS);
    wr(A_DIV, 8'h00);
    $display("test misc done");
  endtask

  // Main sequence: reset for two cycles, then every scenario in turn.
  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    temp_out = 16'hA1B2;
    x_rate = 16'hC3D4;
    y_rate = 16'hE5F6;
    z_rate = 16'h0718;
    frame_sync_pin = 0;
    fifo_full = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    t_reset();
    t_gyro();
    t_low_power();
    t_queue();
    t_full();
    t_frame_sync_pin();
    t_misc();
    report_and_stop();
  end
endmodule
